// *** design/tcc_core.sv ***
/*
 * Timer counter core: APB register file, prescaler, up/down counter with
 * wraparound, single pass, stop command and compare channels.
 * Assumes gen_tick and event_in are one-cycle pulses synchronous to clock.
 */
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module tcc_core #(
    parameter int CW = tcc_pkg::CNT_W
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              gen_tick,
    input  wire logic              event_in,
    input  wire logic              odd_instance,
    input  wire logic              debug_halt,
    output logic      [1:0]        wave_out,
    output logic                   wrap_event,
    output logic      [1:0]        match_event,
    output logic                   dma_req
);
    import tcc_pkg::*;

    tcc_ctrl_s        ctrl_reg;
    tcc_second_control_reg_s       second_control_reg_reg;
    tcc_evctrl_s      evctrl_reg;
    logic             halt_reg;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic [7:0]       cycle_reg;
    logic [CW-1:0]    cc_reg [2];
    logic             stopped_reg;
    logic             running_reg;
    logic             start_pend_reg;
    logic             wrap_flag_reg;
    logic [1:0]       match_flag_reg;
    logic [DIV_W-1:0] presc_cnt_reg;
    logic             presc_out_reg;

    function automatic logic [CW-1:0] all_ones(input logic [1:0] mode);
        case (mode)
            MODE_BYTE: all_ones = CW'(8'hff);
            MODE_WORD: all_ones = '1;
            default:   all_ones = CW'(16'hffff);
        endcase
    endfunction

    wire              access    = psel && penable && pready;
    wire              wr        = access && pwrite;
    wire              follower  = odd_instance && (ctrl_reg.mode == MODE_WORD);
    wire tcc_ctrl_s   wctrl     = tcc_ctrl_s'(pwdata[11:0]);
    wire tcc_second_control_reg_s  wctrlb    = tcc_second_control_reg_s'(pwdata[3:0]);
    wire              wr_ctrl   = wr && (paddr == OFS_CTRL);
    wire              wr_clr    = wr && (paddr == OFS_CLR);
    wire              wr_set    = wr && (paddr == OFS_SET);
    wire              wr_ev     = wr && (paddr == OFS_EVCTRL);
    wire              wr_flag   = wr && (paddr == OFS_INTFLAG);
    wire              wr_cnt_raw = wr && (paddr == OFS_COUNT);
    wire              wr_count  = wr_cnt_raw && !follower;
    wire              wr_cc0    = wr && (paddr == OFS_CC0) && !follower;
    wire              wr_cc1    = wr && (paddr == OFS_CC1) && !follower;
    wire              wr_cycle  = wr && (paddr == OFS_CYCLE) && (ctrl_reg.mode == MODE_BYTE);
    wire              soft_rst  = wr_ctrl && wctrl.soft_reset_bit;
    wire              protect_ok = !ctrl_reg.enable;
    wire              start_cmd = wr_ctrl && wctrl.enable && !ctrl_reg.enable;
    wire              stop_cmd  = wr_set && (wctrlb.cmd == CMD_STOP);

    wire [CW-1:0]     mask      = all_ones(ctrl_reg.mode);
    wire [CW-1:0]     wdata_m   = pwdata[CW-1:0] & mask;
    wire              match_top = (ctrl_reg.wave == WAVE_MFRQ) || (ctrl_reg.wave == WAVE_MPWM);
    wire [CW-1:0]     cycle_top = (ctrl_reg.mode == MODE_BYTE) ? CW'(cycle_reg) : mask;
    wire [CW-1:0]     top       = match_top ? (cc_reg[0] & mask) : cycle_top;
    wire              at_top    = (count_reg == top);
    wire              at_zero   = (count_reg == '0);
    wire              dir       = second_control_reg_reg.dir;

    wire [DIV_W-1:0]  div       = div_limit(ctrl_reg.presc);
    wire              presc_hit = gen_tick && (presc_cnt_reg == div);
    wire              ev_count  = (evctrl_reg.input_event_action == INPUT_EVENT_ACTION_COUNT);
    wire              halted    = debug_halt && !halt_reg;
    wire              src_tick  = ev_count ? event_in : presc_hit;
    wire              tick      = running_reg && !halted && !follower && src_tick;
    // A pending start waits for the chosen update edge so the first count is aligned.
    wire              upd       = ((ctrl_reg.resync == SYNC_PRESC) && (div != '0)) ? presc_hit : gen_tick;
    wire              go        = start_pend_reg && upd && ctrl_reg.enable;
    wire              wrap      = tick && (dir ? at_zero : at_top);
    wire              do_stop   = stop_cmd && running_reg;
    wire [1:0]        hit       = {tick && (count_reg == (cc_reg[1] & mask)),
                                   tick && (count_reg == (cc_reg[0] & mask))};
    wire [CW-1:0]     start_val = dir ? top : '0;

    // Software write first, then stop reload, then start, then counting.
    always_comb begin
        count_next = count_reg;
        if (wr_count) begin
            count_next = wdata_m;
        end else if (do_stop) begin
            count_next = start_val;
        end else if (go && at_zero && dir) begin
            count_next = top;
        end else if (wrap) begin
            count_next = dir ? top : '0;
        end else if (tick) begin
            count_next = (dir ? count_reg - CW'(1) : count_reg + CW'(1)) & mask;
        end
    end

    wire [31:0] st_word = {27'h0, follower, 3'h0, stopped_reg};
    wire [31:0] if_word = {26'h0, match_flag_reg, 3'h0, wrap_flag_reg};
    wire        mapped  = (paddr[1:0] == 2'h0) && (paddr <= OFS_HALT);
    wire [31:0] rdata   = (paddr == OFS_CTRL)    ? {20'h0, ctrl_reg[11:1], 1'b0} :
                          (paddr == OFS_CLR)     ? {30'h0, second_control_reg_reg.single, second_control_reg_reg.dir} :
                          (paddr == OFS_SET)     ? {30'h0, second_control_reg_reg.single, second_control_reg_reg.dir} :
                          (paddr == OFS_EVCTRL)  ? {26'h0, evctrl_reg} :
                          (paddr == OFS_STATUS)  ? st_word :
                          (paddr == OFS_INTFLAG) ? if_word :
                          (paddr == OFS_COUNT)   ? 32'(count_reg) :
                          (paddr == OFS_CYCLE)   ? {24'h0, cycle_reg} :
                          (paddr == OFS_CC0)     ? 32'(cc_reg[0]) :
                          (paddr == OFS_CC1)     ? 32'(cc_reg[1]) :
                          (paddr == OFS_HALT)    ? {31'h0, halt_reg} : 32'h0;

    // One wait-free access phase: pready rises in the cycle after setup.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !mapped;
            prdata  <= (psel && !penable) ? rdata : 32'h0;
        end
    end

    // The halt behaviour survives soft reset so a debugger keeps its setting.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            halt_reg <= 1'b0;
        end else if (wr && (paddr == OFS_HALT)) begin
            halt_reg <= pwdata[0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || soft_rst) begin
            ctrl_reg   <= CTRL_RST;
            evctrl_reg <= EVCTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg           <= protect_ok ? wctrl : ctrl_reg;
                ctrl_reg.soft_reset_bit     <= 1'b0;
                ctrl_reg.enable    <= wctrl.enable;
                ctrl_reg.keepalive <= wctrl.keepalive;
            end
            if (wr_ev) begin
                evctrl_reg       <= tcc_evctrl_s'(pwdata[5:0]);
                evctrl_reg.input_event_action <= protect_ok ? wctrl[2:0] : evctrl_reg.input_event_action;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || soft_rst) begin
            second_control_reg_reg <= SECOND_CONTROL_REG_RST;
        end else if (wr_set) begin
            second_control_reg_reg.dir    <= second_control_reg_reg.dir | wctrlb.dir;
            second_control_reg_reg.single <= second_control_reg_reg.single | wctrlb.single;
        end else if (wr_clr) begin
            second_control_reg_reg.dir    <= second_control_reg_reg.dir & ~wctrlb.dir;
            second_control_reg_reg.single <= second_control_reg_reg.single & ~wctrlb.single;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || soft_rst) begin
            count_reg <= '0;
            cycle_reg <= 8'h00;
            cc_reg[0] <= '0;
            cc_reg[1] <= '0;
        end else begin
            count_reg <= count_next;
            cycle_reg <= wr_cycle ? pwdata[7:0] : cycle_reg;
            cc_reg[0] <= wr_cc0 ? wdata_m : cc_reg[0];
            cc_reg[1] <= wr_cc1 ? wdata_m : cc_reg[1];
        end
    end

    // The toggle output marks the divided clock; the counter uses its terminal pulse.
    always_ff @(posedge clock) begin
        if (sys_rst || soft_rst || !ctrl_reg.enable) begin
            presc_cnt_reg <= '0;
            presc_out_reg <= 1'b0;
        end else if (presc_hit) begin
            presc_cnt_reg <= '0;
            presc_out_reg <= !presc_out_reg;
        end else if (gen_tick) begin
            presc_cnt_reg <= presc_cnt_reg + DIV_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || soft_rst) begin
            running_reg    <= 1'b0;
            start_pend_reg <= 1'b0;
            stopped_reg    <= 1'b1;
        end else if (wr_ctrl && !wctrl.enable) begin
            running_reg    <= 1'b0;
            start_pend_reg <= 1'b0;
        end else if (do_stop || (wrap && second_control_reg_reg.single)) begin
            running_reg    <= 1'b0;
            stopped_reg    <= 1'b1;
        end else if (start_cmd) begin
            start_pend_reg <= 1'b1;
        end else if (go) begin
            start_pend_reg <= 1'b0;
            running_reg    <= 1'b1;
            stopped_reg    <= 1'b0;
        end
    end

    // A hardware set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clock) begin
        if (sys_rst || soft_rst) begin
            wrap_flag_reg  <= 1'b0;
            match_flag_reg <= 2'h0;
            wave_out       <= 2'h0;
            wrap_event     <= 1'b0;
            match_event    <= 2'h0;
            dma_req        <= 1'b0;
        end else begin
            wrap_flag_reg  <= wrap | (wrap_flag_reg & ~(wr_flag & pwdata[0]));
            match_flag_reg <= hit | (match_flag_reg & ~({2{wr_flag}} & pwdata[5:4]));
            wave_out       <= do_stop ? 2'h0 : (wave_out ^ hit);
            wrap_event     <= wrap && evctrl_reg.wrap_eo;
            match_event    <= hit & evctrl_reg.match_eo;
            dma_req        <= hit[0];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_up_wrap;
        tick && !dir && at_top && !wr_count && !do_stop |=> (count_reg == '0) && wrap_flag_reg;
    endproperty
    a_up_wrap: assert property (p_up_wrap) else $error("up count did not wrap to zero");

    property p_down_reload;
        tick && dir && at_zero && !wr_count && !do_stop && !soft_rst |=> count_reg == $past(top);
    endproperty
    a_down_reload: assert property (p_down_reload) else $error("down count did not reload");

    property p_sw_write;
        wr_count && !soft_rst |=> count_reg == $past(wdata_m);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("count write lost");

    property p_protect;
        wr_ctrl && ctrl_reg.enable && !wctrl.soft_reset_bit |=> $stable(ctrl_reg.mode) && $stable(ctrl_reg.presc);
    endproperty
    a_protect: assert property (p_protect) else $error("protected field changed while enabled");

    property p_soft_reset;
        soft_rst |=> (ctrl_reg.mode == MODE_HALF) && !ctrl_reg.enable && !running_reg;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

    property p_single;
        wrap && second_control_reg_reg.single && !soft_rst |=> !running_reg && stopped_reg ##1 !tick;
    endproperty
    a_single: assert property (p_single) else $error("single pass kept counting");

    property p_stop;
        do_stop && !soft_rst && !wr_ctrl |=> stopped_reg && (wave_out == 2'h0) && !running_reg;
    endproperty
    a_stop: assert property (p_stop) else $error("stop command not honoured");

    property p_follower;
        follower && wr_cnt_raw && !tick |=> $stable(count_reg);
    endproperty
    a_follower: assert property (p_follower) else $error("follower count changed by write");

    property p_ev_bypass;
        ev_count && !event_in |-> !tick;
    endproperty
    a_ev_bypass: assert property (p_ev_bypass) else $error("tick without event in event mode");

    property p_wrap_event;
        wrap && evctrl_reg.wrap_eo && !soft_rst |=> wrap_event ##1 !wrap_event || $past(wrap);
    endproperty
    a_wrap_event: assert property (p_wrap_event) else $error("wrap event missing");

endmodule

// *** pkg/tcc_pkg.sv ***
/*
 * Shared constants, register map and carrier types of the timer counter core.
 * Assumes a single 100 MHz clock and an APB master with 32-bit data.
 */
package tcc_pkg;

    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CLR     = 8'h04;
    localparam logic [7:0] OFS_SET     = 8'h08;
    localparam logic [7:0] OFS_EVCTRL  = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_INTFLAG = 8'h14;
    localparam logic [7:0] OFS_COUNT   = 8'h18;
    localparam logic [7:0] OFS_CYCLE   = 8'h1c;
    localparam logic [7:0] OFS_CC0     = 8'h20;
    localparam logic [7:0] OFS_CC1     = 8'h24;
    localparam logic [7:0] OFS_HALT    = 8'h28;

    localparam logic [1:0] MODE_HALF = 2'h0;
    localparam logic [1:0] MODE_BYTE = 2'h1;
    localparam logic [1:0] MODE_WORD = 2'h2;

    localparam logic [1:0] WAVE_NFRQ = 2'h0;
    localparam logic [1:0] WAVE_MFRQ = 2'h1;
    localparam logic [1:0] WAVE_NPWM = 2'h2;
    localparam logic [1:0] WAVE_MPWM = 2'h3;

    localparam logic [1:0] SYNC_GEN   = 2'h0;
    localparam logic [1:0] SYNC_PRESC = 2'h1;

    localparam logic [1:0] CMD_STOP    = 2'h2;
    localparam logic [2:0] INPUT_EVENT_ACTION_COUNT = 3'h2;

    localparam int CNT_W = 32;
    localparam int DIV_W = 10;

    typedef struct packed {
        logic [1:0] resync;
        logic [2:0] presc;
        logic       keepalive;
        logic [1:0] wave;
        logic [1:0] mode;
        logic       enable;
        logic       soft_reset_bit;
    } tcc_ctrl_s;

    typedef struct packed {
        logic [1:0] cmd;
        logic       single;
        logic       dir;
    } tcc_second_control_reg_s;

    typedef struct packed {
        logic [1:0] match_eo;
        logic       wrap_eo;
        logic [2:0] input_event_action;
    } tcc_evctrl_s;

    localparam tcc_ctrl_s   CTRL_RST   = '{resync: SYNC_GEN, presc: 3'h0, keepalive: 1'b0,
                                           wave: WAVE_NFRQ, mode: MODE_HALF, enable: 1'b0, soft_reset_bit: 1'b0};
    localparam tcc_second_control_reg_s  SECOND_CONTROL_REG_RST  = '{cmd: 2'h0, single: 1'b0, dir: 1'b0};
    localparam tcc_evctrl_s EVCTRL_RST = '{match_eo: 2'h0, wrap_eo: 1'b0, input_event_action: 3'h0};

    // Prescaler terminal count: division by 1, 2, 4, 8, 16, 64, 256 and 1024.
    function automatic logic [DIV_W-1:0] div_limit(input logic [2:0] sel);
        case (sel)
            3'h0:    div_limit = 10'h000;
            3'h1:    div_limit = 10'h001;
            3'h2:    div_limit = 10'h003;
            3'h3:    div_limit = 10'h007;
            3'h4:    div_limit = 10'h00f;
            3'h5:    div_limit = 10'h03f;
            3'h6:    div_limit = 10'h0ff;
            default: div_limit = 10'h3ff;
        endcase
    endfunction

endpackage

// *** tb/tcc_core_test.sv ***
/*
 * Self-checking bench of the timer counter core: a table of register accesses,
 * then enable protection, one-shot wrap, soft reset, stop and event counting.
 * Assumes the APB slave answers with pready and the far-side model in tcc_far_side.
 */
`timescale 1ns/10ps
module tcc_core_test;
    import tcc_pkg::*;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        e;
    } tcc_row_s;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        gen_tick;
    logic        event_in;
    logic [1:0]  wave_out;
    logic        wrap_event;
    logic        dma_req;
    logic [3:0]  tick_gap = 4'h0;
    logic        fire_event = 1'b0;
    logic        odd_instance = 1'b0;
    logic [31:0] q;
    logic [31:0] c1;
    logic        e;
    int          n_dma;
    int          n_wrap;
    int          n_mismatch = 0;
    int          comparisons = 0;
    tcc_row_s    rows [13] = '{
        '{1'b0, OFS_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_STATUS, 32'h0, 32'h1, 1'b0},
        '{1'b0, OFS_COUNT, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_INTFLAG, 32'h0, 32'h0, 1'b0},
        '{1'b0, OFS_HALT, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h2c, 32'h5, 32'h0, 1'b1},
        '{1'b1, OFS_COUNT, 32'h1234, 32'h1234, 1'b0}, '{1'b1, OFS_CYCLE, 32'h55, 32'h0, 1'b0},
        '{1'b1, OFS_SET, 32'h3, 32'h3, 1'b0}, '{1'b1, OFS_CLR, 32'h1, 32'h2, 1'b0},
        '{1'b1, OFS_SET, 32'h0, 32'h2, 1'b0}, '{1'b1, OFS_CLR, 32'h2, 32'h0, 1'b0},
        '{1'b1, OFS_COUNT, 32'h0, 32'h0, 1'b0}};

    always #5 clock = ~clock;

    tcc_core u_tcc_core (.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gen_tick(gen_tick), .event_in(event_in), .odd_instance(odd_instance), .debug_halt(1'b0),
        .wave_out(wave_out), .wrap_event(wrap_event), .match_event(), .dma_req(dma_req));
    tcc_far_side u_tcc_far_side (.clock(clock), .sys_rst(sys_rst), .tick_gap(tick_gap),
        .fire_event(fire_event), .dma_req(dma_req), .wrap_event(wrap_event), .gen_tick(gen_tick),
        .event_in(event_in), .n_dma(n_dma), .n_wrap(n_wrap));

    // The request is held until pready is seen at an edge; an idle edge follows so no signal is driven twice.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (x !== g) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask

    task automatic results;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        results();
    end

    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk("row data", rows[i].x, q);
            chk("row error", {31'h0, rows[i].e}, {31'h0, e});
        end
        // Protected fields take the write that sets enable, not one made while enabled or clearing it.
        apb(1'b1, OFS_CTRL, 32'h6);
        apb(1'b1, OFS_CTRL, 32'ha);
        rd_chk("ctrl enabled", OFS_CTRL, 32'h6);
        apb(1'b1, OFS_CTRL, 32'h0);
        rd_chk("ctrl disabled", OFS_CTRL, 32'h4);
        apb(1'b1, OFS_CYCLE, 32'h3);
        apb(1'b1, OFS_EVCTRL, 32'h8);
        apb(1'b1, OFS_SET, 32'h2);
        tick_gap <= 4'h1;
        apb(1'b1, OFS_CTRL, 32'h6);
        for (int n = 0; n < 200 && q[0] !== 1'b1; n++) apb(1'b0, OFS_INTFLAG, 32'h0);
        chk("wrap flag", 32'h1, {31'h0, q[0]});
        rd_chk("one shot count", OFS_COUNT, 32'h0);
        repeat (20) @(posedge clock);
        rd_chk("one shot hold", OFS_COUNT, 32'h0);
        chk("wrap events", 32'h1, n_wrap);
        // Soft reset after a disable spares only the halt register.
        apb(1'b1, OFS_HALT, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        rd_chk("ctrl after soft_reset_bit", OFS_CTRL, 32'h0);
        rd_chk("evctrl after soft_reset_bit", OFS_EVCTRL, 32'h0);
        rd_chk("halt after soft_reset_bit", OFS_HALT, 32'h1);
        apb(1'b1, OFS_SET, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h2);
        repeat (30) @(posedge clock);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk("down count", 32'h1, {31'h0, q < 32'hffff && q > 32'hff00});
        apb(1'b1, OFS_SET, 32'h8);
        rd_chk("count after stop", OFS_COUNT, 32'hffff);
        rd_chk("stopped", OFS_STATUS, 32'h1);
        chk("waves after stop", 32'h0, {30'h0, wave_out});
        // Events counted while the tick source keeps running must bypass the prescaler.
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CLR, 32'h1);
        apb(1'b1, OFS_COUNT, 32'h0);
        apb(1'b1, OFS_EVCTRL, {29'h0, INPUT_EVENT_ACTION_COUNT});
        tick_gap <= 4'h3;
        apb(1'b1, OFS_CTRL, 32'h2);
        repeat (10) @(posedge clock);
        apb(1'b0, OFS_COUNT, 32'h0);
        c1 = q;
        repeat (5) begin
            fire_event <= 1'b1;
            @(posedge clock);
            fire_event <= 1'b0;
            repeat (3) @(posedge clock);
        end
        rd_chk("event count", OFS_COUNT, c1 + 32'h5);
        // Compare values are zero, so the first tick of each up-counting run from zero matches both channels; the down run never reaches zero.
        chk("dma requests", 32'h2, n_dma);
        chk("waves after match", 32'h3, {30'h0, wave_out});
        // An odd instance in word mode must ignore count writes and report itself as follower.
        odd_instance <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h8);
        apb(1'b1, OFS_COUNT, 32'h77);
        rd_chk("follower count", OFS_COUNT, c1 + 32'h5);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("follower flag", 32'h1, {31'h0, q[4]});
        results();
    end
endmodule

// *** tb/tcc_far_side.sv ***
/*
 * Far-side model: generic tick source, event system pulses and sinks that
 * count the DMA requests and wrap events coming back from the core.
 * Assumes one clock shared with the core and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module tcc_far_side (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [3:0] tick_gap,
    input  wire logic       fire_event,
    input  wire logic       dma_req,
    input  wire logic       wrap_event,
    output logic            gen_tick,
    output logic            event_in,
    output int              n_dma,
    output int              n_wrap
);
    logic [3:0] gap_reg;

    // A gap of zero parks the tick source, so no tick sneaks in while the bench idles.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gap_reg  <= 4'h0;
            gen_tick <= 1'b0;
            event_in <= 1'b0;
            n_dma    <= 0;
            n_wrap   <= 0;
        end else begin
            gap_reg  <= (gap_reg == 4'h0) ? tick_gap : gap_reg - 4'h1;
            gen_tick <= (tick_gap != 4'h0) && (gap_reg == 4'h0);
            event_in <= fire_event;
            n_dma    <= n_dma + int'(dma_req);
            n_wrap   <= n_wrap + int'(wrap_event);
        end
    end
endmodule
